// ### shared/ndcf_consts.vh
// Purpose: constants of the nand dma command intake and ecc formatter
// Assumes: apb with 32-bit data, one word per register
// Notes:   offsets are byte addresses
`ifndef NDCF_CONSTS_VH
`define NDCF_CONSTS_VH
// ============================================================
// register offsets
`define NDCF_CTRL_OFS      8'h00
`define NDCF_STATUS_OFS    8'h04
`define NDCF_CMDWORD_OFS   8'h08
`define NDCF_DATAPORT_OFS  8'h10
// ============================================================
// control fields
`define NDCF_CTRL_DMAEN    0
`define NDCF_CTRL_ECCEN    1
`define NDCF_CTRL_SEC1K    2
`define NDCF_CTRL_SPARE    3
`define NDCF_CTRL_LVL_LO   4
`define NDCF_CTRL_LVL_HI   5
// status fields
`define NDCF_ST_DONE       0
`define NDCF_ST_UNSUP      1
`define NDCF_ST_ECCERR     2
// ============================================================
// command tags
`define NDCF_CLASS_PIPE    2'h2
`define NDCF_TAG_PIPE      4'h2
`define NDCF_SUB_READ      4'h0
`define NDCF_SUB_WRITE     4'h1
`define NDCF_SUB_ADDRHI    4'h2
`define NDCF_SUB_ADDRLO    4'h3
`define NDCF_SUB_LAST      4'h4
`define NDCF_BEAT_STRB     4'h3
// ============================================================
// ecc geometry and queue depth
`define NDCF_SEC_SMALL     11'h200
`define NDCF_SEC_LARGE     11'h400
`define NDCF_CHK_4         6'h08
`define NDCF_CHK_8         6'h0E
`define NDCF_CHK_16        6'h1A
`define NDCF_CHK_24        6'h2A
`define NDCF_QDEPTH        3'h4
`endif

// ### rtl/ndcf_top.v
// Purpose: dma command intake, queue and page ecc formatter
// Assumes: apb4 slave, pready always high, same-clock engine
// Notes:   check bytes come from a 16-bit syndrome register
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ndcf_consts.vh"
module ndcf_top
(
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   output wire        cmdValid,
   input  wire        cmdTake,
   output reg         cmdWrite,
   output reg  [7:0]  cmdPageCount,
   output reg  [31:0] cmdBufAddr,
   output reg  [7:0]  cmdBurstLen,
   input  wire        cmdDone,
   output reg         pipeStrobe,
   output reg  [31:0] pipeCmd,
   output reg  [31:0] pipeData,
   output wire        dmaIdle,
   input  wire [7:0]  eccIn,
   input  wire        eccInValid,
   output wire        eccInReady,
   output reg  [7:0]  eccOut,
   output reg         eccOutValid,
   input  wire        eccOutReady,
   input  wire        pageStart,
   input  wire        pageWrite
);
   // ============================================================
   // decode helpers
   // check byte count per correction level
   function [5:0] chkLen;
      input [1:0] lvl;
      begin
         case (lvl)
            2'h0:    chkLen = `NDCF_CHK_4;
            2'h1:    chkLen = `NDCF_CHK_8;
            2'h2:    chkLen = `NDCF_CHK_16;
            default: chkLen = `NDCF_CHK_24;
         endcase
      end
   endfunction
   // syndrome step over one byte, polynomial 0x1021
   function [15:0] synStep;
      input [15:0] s;
      input [7:0]  d;
      integer      i;
      reg   [15:0] t;
      begin
         t = s;
         for (i = 7; i >= 0; i = i - 1)
            t = {t[14:0], 1'b0} ^ ((t[15] ^ d[i]) ? 16'h1021 : 16'h0000);
         synStep = t;
      end
   endfunction
   // ============================================================
   // apb access
   reg  [31:0] ctrl_r;          // mode bits
   reg  [2:0]  status_r;        // sticky flags, write one to clear
   reg  [31:0] cmdWord_r;       // command half of a pair
   wire        setup  = psel & ~penable;
   wire        wrAcc  = psel & penable & pwrite;
   wire        hitCtl = (paddr == `NDCF_CTRL_OFS);
   wire        hitSt  = (paddr == `NDCF_STATUS_OFS);
   wire        hitCmd = (paddr == `NDCF_CMDWORD_OFS);
   wire        hitDp  = (paddr == `NDCF_DATAPORT_OFS);
   wire        mapped = hitCtl | hitSt | hitCmd | hitDp;
   wire        dmaOn  = ctrl_r[`NDCF_CTRL_DMAEN];
   assign pready  = 1'b1;
   assign pslverr = psel & penable & (~mapped | (hitDp & ~pwrite));
   // dataport writes: full word is a pair, low half lane a beat
   wire        dpWr   = wrAcc & hitDp;
   wire        beatWr = dpWr & (pstrb == `NDCF_BEAT_STRB);
   wire        pairWr = dpWr & (pstrb == 4'hF);
   wire [15:0] beat   = pwdata[15:0];
   // ============================================================
   // queue and staging state
   reg  [49:0] q_r [0:3];       // {int, write, pages, addr, burst}
   reg  [1:0]  qWr_r;           // write index
   reg  [1:0]  qRd_r;           // read index
   reg  [2:0]  qCnt_r;          // occupancy
   reg  [1:0]  pairIdx_r;       // next pair expected
   reg  [1:0]  beatIdx_r;       // next beat expected
   reg         stWrite_r;       // staged direction
   reg  [7:0]  stPages_r;       // staged page count
   reg  [15:0] stHi_r;          // staged address high
   reg  [15:0] stLo_r;          // staged address low
   reg         actInt_r;        // int request of running command
   reg  [49:0] enq;             // entry built on fourth part
   reg         enqGo;           // fourth part accepted intact
   reg         unsup;           // protocol violation this cycle
   reg         pipeGo;          // plain pipeline command
   reg         eccErrEv;        // check byte mismatch this cycle
   reg  [1:0]  pairIdx_nxt;
   reg  [1:0]  beatIdx_nxt;
   wire [3:0]  sub    = pwdata[11:8];
   wire        tagOk  = (pwdata[15:12] == `NDCF_TAG_PIPE) &
                        (pwdata[31:16] == 16'h0000);
   wire        clsOk  = (cmdWord_r[31:28] == 4'h0) &
                        (cmdWord_r[27:26] == `NDCF_CLASS_PIPE) &
                        (cmdWord_r[25:24] == 2'h0);
   wire        qFull  = (qCnt_r == `NDCF_QDEPTH);
   wire        deq    = cmdValid & cmdTake;
   assign cmdValid = (qCnt_r != 3'h0);
   assign dmaIdle  = ~cmdValid & (pairIdx_r == 2'h0) &
                     (beatIdx_r == 2'h0);
   // ============================================================
   // command decode, pair and beat forms share one entry layout
   always @*
   begin
      enq         = 50'h0;
      enqGo       = 1'b0;
      unsup       = 1'b0;
      pipeGo      = 1'b0;
      pairIdx_nxt = pairIdx_r;
      beatIdx_nxt = beatIdx_r;
      if (pairWr)
      begin
         // a pair while beats are half done is an interleave
         if (beatIdx_r != 2'h0)
         begin
            unsup       = 1'b1;
            beatIdx_nxt = 2'h0;
         end
         case (pairIdx_r)
            2'h0:
            begin
               if (dmaOn & clsOk & tagOk & (pwdata[7:0] != 8'h00 |
                   1'b1) & (sub == `NDCF_SUB_READ |
                   sub == `NDCF_SUB_WRITE))
                  pairIdx_nxt = 2'h1;
               else if (cmdWord_r[27:26] == `NDCF_CLASS_PIPE)
                  pipeGo = 1'b1;
               else if (dmaOn)
                  unsup = 1'b1;
               else
                  pipeGo = 1'b1;
            end
            2'h1:
            begin
               if (clsOk & tagOk & (sub == `NDCF_SUB_ADDRHI) &
                   (pwdata[7:0] == 8'h00))
                  pairIdx_nxt = 2'h2;
               else
               begin
                  unsup       = 1'b1;
                  pairIdx_nxt = 2'h0;
               end
            end
            2'h2:
            begin
               if (clsOk & tagOk & (sub == `NDCF_SUB_ADDRLO) &
                   (pwdata[7:0] == 8'h00))
                  pairIdx_nxt = 2'h3;
               else
               begin
                  unsup       = 1'b1;
                  pairIdx_nxt = 2'h0;
               end
            end
            default:
            begin
               pairIdx_nxt = 2'h0;
               if (clsOk & tagOk & (sub == `NDCF_SUB_LAST) &
                   (pwdata[7:0] == 8'h00) &
                   (cmdWord_r[23:17] == 7'h00) &
                   (cmdWord_r[7:0] == 8'h00))
               begin
                  enq   = {cmdWord_r[16], stWrite_r, stPages_r,
                           stHi_r, stLo_r, cmdWord_r[15:8]};
                  enqGo = 1'b1;
               end
               else
                  unsup = 1'b1;
            end
         endcase
      end
      else if (beatWr)
      begin
         // beats mid-pair interleave, beats with dma off rejected
         if (~dmaOn | (pairIdx_r != 2'h0))
         begin
            unsup       = 1'b1;
            pairIdx_nxt = 2'h0;
            beatIdx_nxt = 2'h0;
         end
         else
         begin
            case (beatIdx_r)
               2'h0:
               begin
                  if ((beat[15:12] == `NDCF_TAG_PIPE) &
                      (beat[11:8] == `NDCF_SUB_READ |
                       beat[11:8] == `NDCF_SUB_WRITE))
                     beatIdx_nxt = 2'h1;
                  else
                     unsup = 1'b1;
               end
               2'h1:    beatIdx_nxt = 2'h2;
               2'h2:    beatIdx_nxt = 2'h3;
               default:
               begin
                  beatIdx_nxt = 2'h0;
                  if (beat[15:9] == 7'h00)
                  begin
                     enq   = {beat[8], stWrite_r, stPages_r,
                              stHi_r, stLo_r, beat[7:0]};
                     enqGo = 1'b1;
                  end
                  else
                     unsup = 1'b1;
               end
            endcase
         end
      end
      else if (wrAcc & hitCmd & (pairIdx_r != 2'h0) &
               (cmdWord_r[27:26] != `NDCF_CLASS_PIPE))
         unsup = 1'b0;
      // full queue drops the command
      if (enqGo & qFull)
      begin
         enqGo = 1'b0;
         unsup = 1'b1;
      end
   end
   // ============================================================
   // staging, queue and status registers
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         ctrl_r     <= 32'h0000_0000;
         status_r   <= 3'h0;
         cmdWord_r  <= 32'h0000_0000;
         pairIdx_r  <= 2'h0;
         beatIdx_r  <= 2'h0;
         stWrite_r  <= 1'b0;
         stPages_r  <= 8'h00;
         stHi_r     <= 16'h0000;
         stLo_r     <= 16'h0000;
         qWr_r      <= 2'h0;
         qRd_r      <= 2'h0;
         qCnt_r     <= 3'h0;
         actInt_r   <= 1'b0;
         pipeStrobe <= 1'b0;
         pipeCmd    <= 32'h0000_0000;
         pipeData   <= 32'h0000_0000;
         prdata     <= 32'h0000_0000;
      end
      else
      begin
         pairIdx_r  <= pairIdx_nxt;
         beatIdx_r  <= beatIdx_nxt;
         pipeStrobe <= pipeGo;
         if (pipeGo)
         begin
            pipeCmd  <= cmdWord_r;
            pipeData <= pwdata;
         end
         if (wrAcc & hitCtl)
            ctrl_r <= {26'h0, pwdata[5:0]};
         if (wrAcc & hitCmd)
            cmdWord_r <= pwdata;
         // staging fields; host keeps the address 32-bit aligned
         if (pairWr & (pairIdx_nxt == 2'h1))
         begin
            stWrite_r <= pwdata[8];
            stPages_r <= pwdata[7:0];
         end
         if (pairWr & (pairIdx_nxt == 2'h2))
            stHi_r <= cmdWord_r[23:8];
         if (pairWr & (pairIdx_nxt == 2'h3))
            stLo_r <= cmdWord_r[23:8];
         if (beatWr & (beatIdx_nxt == 2'h1))
         begin
            stWrite_r <= beat[8];
            stPages_r <= beat[7:0];
         end
         if (beatWr & (beatIdx_nxt == 2'h2))
            stHi_r <= beat;
         if (beatWr & (beatIdx_nxt == 2'h3))
            stLo_r <= beat;
         // queue indices
         if (enqGo)
         begin
            q_r[qWr_r] <= enq;
            qWr_r      <= qWr_r + 2'h1;
         end
         if (deq)
         begin
            qRd_r    <= qRd_r + 2'h1;
            actInt_r <= q_r[qRd_r][49];
         end
         if (enqGo & ~deq)
            qCnt_r <= qCnt_r + 3'h1;
         else if (~enqGo & deq)
            qCnt_r <= qCnt_r - 3'h1;
         // sticky flags: a new event wins over a clear
         status_r <= (status_r & ~((wrAcc & hitSt) ? pwdata[2:0]
                                                    : 3'h0))
                     | {eccErrEv, unsup, cmdDone & actInt_r};
         // read data captured in setup, stable in access phase
         if (setup)
         begin
            if (hitCtl)
               prdata <= ctrl_r;
            else if (hitSt)
               prdata <= {16'h0, 5'h0, qCnt_r, 5'h0, status_r};
            else if (hitCmd)
               prdata <= cmdWord_r;
            else
               prdata <= 32'h0000_0000;
         end
      end
   end
   // head of queue fields
   always @*
   begin
      {cmdWrite, cmdPageCount, cmdBufAddr, cmdBurstLen} = q_r[qRd_r][48:0];
   end
   // ============================================================
   // ecc page formatter
   reg  [10:0] secCnt_r;        // bytes of current sector
   reg  [5:0]  chkCnt_r;        // check bytes of current sector
   reg         inChk_r;         // emitting or consuming check bytes
   reg  [15:0] syn_r;           // running syndrome
   wire        eccOn   = ctrl_r[`NDCF_CTRL_ECCEN] &
                         ~ctrl_r[`NDCF_CTRL_SPARE];
   wire [1:0]  lvl     = ctrl_r[`NDCF_CTRL_LVL_HI:`NDCF_CTRL_LVL_LO];
   wire [10:0] secLen  = (lvl == 2'h3 | ctrl_r[`NDCF_CTRL_SEC1K])
                         ? `NDCF_SEC_LARGE : `NDCF_SEC_SMALL;
   wire        canLoad = ~eccOutValid | eccOutReady;
   wire        genChk  = eccOn & inChk_r & pageWrite;
   wire        eatChk  = eccOn & inChk_r & ~pageWrite;
   assign eccInReady = ~genChk & (eatChk | canLoad);
   wire        inStep  = eccInValid & eccInReady;
   wire        chkStep = genChk ? canLoad : (eatChk & inStep);
   wire        lastChk = (chkCnt_r == chkLen(lvl) - 6'h01);
   // mismatch of a stored check byte against the recomputed one
   always @*
   begin
      eccErrEv = eatChk & inStep & (eccIn != syn_r[7:0]);
   end
   // sector and check byte sequencing
   always @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         secCnt_r    <= 11'h000;
         chkCnt_r    <= 6'h00;
         inChk_r     <= 1'b0;
         syn_r       <= 16'hFFFF;
         eccOut      <= 8'h00;
         eccOutValid <= 1'b0;
      end
      else if (pageStart)
      begin
         secCnt_r    <= 11'h000;
         chkCnt_r    <= 6'h00;
         inChk_r     <= 1'b0;
         syn_r       <= 16'hFFFF;
         eccOutValid <= 1'b0;
      end
      else
      begin
         if (canLoad)
            eccOutValid <= 1'b0;
         if (inChk_r & eccOn)
         begin
            // check bytes follow each sector on the device
            if (chkStep)
            begin
               if (genChk)
               begin
                  eccOut      <= syn_r[7:0];
                  eccOutValid <= 1'b1;
               end
               syn_r    <= lastChk ? 16'hFFFF
                                   : synStep(syn_r, 8'h00);
               chkCnt_r <= lastChk ? 6'h00 : chkCnt_r + 6'h01;
               inChk_r  <= ~lastChk;
            end
         end
         else if (inStep)
         begin
            // data byte, passed unchanged in every mode
            eccOut      <= eccIn;
            eccOutValid <= 1'b1;
            if (eccOn)
            begin
               syn_r <= synStep(syn_r, eccIn);
               if (secCnt_r == secLen - 11'h001)
               begin
                  secCnt_r <= 11'h000;
                  inChk_r  <= 1'b1;
               end
               else
                  secCnt_r <= secCnt_r + 11'h001;
            end
         end
      end
   end
endmodule

// ### tb/ndcf_assertions.sv
// Purpose: port checks of the dma command intake and ecc formatter
// Assumes: one clock, asynchronous active-high reset
// Notes:   bound to the top module at the foot of this file
`timescale 1ns/1ps
module ndcf_assertions
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        cmdValid,
   input wire logic        cmdTake,
   input wire logic [31:0] cmdBufAddr,
   input wire logic        pipeStrobe,
   input wire logic        dmaIdle,
   input wire logic [7:0]  eccOut,
   input wire logic        eccOutValid,
   input wire logic        eccOutReady
);
   // ============================================================
   // helpers
   wire logic accPh    = psel && penable;   // apb access phase
   wire logic addrMiss = paddr != 8'h00 && paddr != 8'h04 &&
                         paddr != 8'h08 && paddr != 8'h10;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // ============================================================
   // assertions
   pready_high_a: assert property (psel |-> pready)
      else $error("pready low during a transfer");
   err_in_access_a: assert property (pslverr |-> accPh)
      else $error("pslverr outside access phase");
   unmapped_err_a: assert property (accPh && addrMiss |-> pslverr)
      else $error("unmapped access not refused");
   port_read_err_a: assert property (
      accPh && !pwrite && paddr == 8'h10 |-> pslverr)
      else $error("data port read not refused");
   port_write_ok_a: assert property (
      accPh && pwrite && paddr == 8'h10 |-> !pslverr)
      else $error("data port write refused");
   idle_flag_a: assert property (cmdValid |-> !dmaIdle)
      else $error("idle while a command is queued");
   pipe_pulse_a: assert property (
      $rose(pipeStrobe) |-> $past(accPh && pwrite && paddr == 8'h10)
      ##1 !pipeStrobe)
      else $error("forward pulse without port write or too long");
   head_hold_a: assert property (
      cmdValid && !cmdTake |=> cmdValid && $stable(cmdBufAddr))
      else $error("queue head changed without a pop");
   ecc_hold_a: assert property (
      eccOutValid && !eccOutReady |=> eccOutValid && $stable(eccOut))
      else $error("ecc output byte dropped while stalled");
   // main scenarios reached
   cover property ($rose(cmdValid));
   cover property (cmdTake);
   cover property (pipeStrobe);
   cover property (eccOutValid && !eccOutReady);
endmodule
bind ndcf_top ndcf_assertions chk (.sys_clk, .rst, .psel, .penable,
   .pwrite, .paddr, .pready, .pslverr, .cmdValid, .cmdTake, .cmdBufAddr,
   .pipeStrobe, .dmaIdle, .eccOut, .eccOutValid, .eccOutReady);

// ### tb/ndcf_dma_model.sv
// Purpose: transfer engine that pops queued dma commands
// Assumes: pops one command per go pulse
// Notes:   done follows the pop after a fixed delay
`timescale 1ns/1ps
module ndcf_dma_model
#(
   parameter int DONE_DLY = 6   // cycles from pop to completion
)
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic go,
   input  wire logic cmdValid,
   output logic      cmdTake,
   output logic      cmdDone
);
   // ============================================================
   // pop and completion
   logic [7:0] cnt_r;   // remaining cycles of the running transfer
   // one pop at a time: a second pop waits for done of the first
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         cmdTake <= 1'b0;
         cmdDone <= 1'b0;
         cnt_r   <= 8'h00;
      end
      else
      begin
         cmdTake <= go && cmdValid && cnt_r == 8'h00 && !cmdTake;
         cmdDone <= cnt_r == 8'h01;
         if (cmdTake)
            cnt_r <= 8'(DONE_DLY);
         else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench of the dma command intake and ecc path
// Assumes: apb slave without wait states expected but not relied on
// Notes:   expected values come from the command layouts only
`timescale 1ns/1ps
module tb;
   // ============================================================
   // signals
   logic sys_clk, rst, psel, penable, pwrite, go, pageStart, pageWrite;
   logic eccInValid, eccOutReady, stall, cmpVal;
   logic [7:0]  paddr, eccIn;
   logic [31:0] pwdata, rdData;
   logic [3:0]  pstrb;
   logic        rdErr;
   wire  [31:0] prdata, cmdBufAddr, pipeCmd, pipeData;
   wire  [7:0]  cmdPageCount, cmdBurstLen, eccOut;
   wire         pready, pslverr, cmdValid, cmdTake, cmdWrite, cmdDone;
   wire         pipeStrobe, dmaIdle, eccInReady, eccOutValid;
   int          mismatches, samplesChecked, pipeCnt, outCnt;
   // ecc runs: control, bytes in, bytes out, direction
   logic [7:0] eCtrl [8] = '{8'h08, 8'h00, 8'h02, 8'h12,
                             8'h22, 8'h32, 8'h06, 8'h02};
   int   eIn  [8] = '{600, 600, 512, 512, 512, 1024, 1024, 520};
   int   eOut [8] = '{600, 600, 520, 526, 538, 1066, 1032, 512};
   logic eWr  [8] = '{1, 1, 1, 1, 1, 1, 1, 0};
   ndcf_top dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .cmdValid, .cmdTake, .cmdWrite,
      .cmdPageCount, .cmdBufAddr, .cmdBurstLen, .cmdDone, .pipeStrobe,
      .pipeCmd, .pipeData, .dmaIdle, .eccIn, .eccInValid, .eccInReady,
      .eccOut, .eccOutValid, .eccOutReady, .pageStart, .pageWrite);
   ndcf_dma_model #(.DONE_DLY(6)) far (.sys_clk, .rst, .go, .cmdValid,
      .cmdTake, .cmdDone);
   // ============================================================
   // clock, forwarded-command count, ecc output watcher
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk)
   begin
      if (pipeStrobe)
         pipeCnt++;
      eccOutReady <= stall ? ~eccOutReady : 1'b1;   // stall every other
      if (pageStart)
         outCnt = 0;                                  // new page, count anew
      else if (eccOutValid && eccOutReady)
      begin
         if (cmpVal)
            check({24'h0, eccOut}, {24'h0, outCnt[7:0]});
         outCnt++;
      end
   end
   // ============================================================
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samplesChecked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task print_verdict();
      if (mismatches == 0 && samplesChecked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one apb transfer, entered and left at a rising edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 100);
      if (n == 100)
         mismatches++;
      rdData = prdata;
      rdErr  = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask
   task rdst(input logic [31:0] mask, input logic [31:0] exp);
      apb(1'b0, 8'h04, 32'h0, 4'hF);
      check(rdData & mask, exp);
   endtask
   // one dma command, as four beats or as four pairs
   task dma(input logic bt, input logic w, input logic [7:0] pg,
            input logic [31:0] ad, input logic it, input logic [7:0] bl);
      if (bt)
      begin
         apb(1'b1, 8'h10, {16'h0, 7'h10, w, pg}, 4'h3);
         apb(1'b1, 8'h10, {16'h0, ad[31:16]}, 4'h3);
         apb(1'b1, 8'h10, {16'h0, ad[15:0]}, 4'h3);
         apb(1'b1, 8'h10, {23'h0, it, bl}, 4'h3);
      end
      else
      begin
         wr(8'h08, 32'h0800_0000);
         wr(8'h10, {16'h0, 7'h10, w, pg});
         wr(8'h08, {8'h08, ad[31:16], 8'h00});
         wr(8'h10, 32'h2200);
         wr(8'h08, {8'h08, ad[15:0], 8'h00});
         wr(8'h10, 32'h2300);
         wr(8'h08, {15'h0400, it, bl, 8'h00});
         wr(8'h10, 32'h2400);
      end
   endtask
   task pop();
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask
   // ============================================================
   // watchdog and main sequence
   initial
   begin
      #(50000 * 5);
      mismatches++;
      print_verdict();
   end
   initial
   begin
      {psel, penable, pwrite, go, pageStart, pageWrite} = 6'h00;
      {eccInValid, stall, cmpVal} = 3'h0;
      paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0; eccIn = 8'h00;
      rst = 1'b1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdst(32'hFFFF_FFFF, 32'h0);
      check({31'h0, dmaIdle}, 32'h1);
      apb(1'b0, 8'h0C, 32'h0, 4'hF);
      check({31'h0, rdErr}, 32'h1);
      apb(1'b0, 8'h10, 32'h0, 4'hF);
      check({31'h0, rdErr}, 32'h1);
      wr(8'h00, 32'h1);
      dma(1'b0, 1'b1, 8'h05, 32'h1234_5678, 1'b1, 8'h10);
      check({cmdValid, cmdWrite, cmdPageCount}, 32'h305);
      check(cmdBufAddr, 32'h1234_5678);
      check({24'h0, cmdBurstLen}, 32'h10);
      dma(1'b1, 1'b0, 8'h03, 32'hABCD_0000, 1'b0, 8'h08);
      rdst(32'h700, 32'h200);
      wr(8'h08, 32'h0800_00AA);
      wr(8'h10, 32'h2500);
      check(pipeCmd, 32'h0800_00AA);
      check(pipeData, 32'h2500);
      @(posedge sys_clk);
      check(pipeCnt, 32'h1);
      wr(8'h08, 32'h0800_0000);
      wr(8'h10, 32'h2101);
      wr(8'h08, 32'h0800_0000);
      wr(8'h10, 32'h2300);
      rdst(32'h702, 32'h202);
      wr(8'h04, 32'h2);
      dma(1'b1, 1'b1, 8'h01, 32'h0000_1000, 1'b0, 8'h04);
      dma(1'b1, 1'b1, 8'h02, 32'h0000_2000, 1'b0, 8'h04);
      dma(1'b0, 1'b1, 8'h02, 32'h0000_3000, 1'b0, 8'h04);
      rdst(32'h702, 32'h402);
      check(cmdBufAddr, 32'h1234_5678);
      pop();
      rdst(32'h703, 32'h303);
      check({cmdValid, cmdWrite, cmdPageCount}, 32'h203);
      check(cmdBufAddr, 32'hABCD_0000);
      wr(8'h04, 32'h3);
      pop();
      rdst(32'h703, 32'h200);
      wr(8'h00, 32'h0);
      apb(1'b1, 8'h10, 32'h2005, 4'h3);
      rdst(32'h702, 32'h202);
      for (int k = 0; k < 8; k++)
      begin
         wr(8'h00, {24'h0, eCtrl[k]});
         stall = k == 0;
         cmpVal = eIn[k] == eOut[k];
         pageWrite <= eWr[k];
         pageStart <= 1'b1;
         @(posedge sys_clk);
         pageStart <= 1'b0;
         eccIn <= 8'h00;
         eccInValid <= 1'b1;
         for (int i = 0; i < eIn[k]; )
         begin
            @(posedge sys_clk);
            if (eccInReady)
               i++;
            eccIn <= i[7:0];
         end
         eccInValid <= 1'b0;
         stall = 1'b0;
         repeat (100) @(posedge sys_clk);
         check(outCnt, eOut[k]);
      end
      rdst(32'h4, 32'h4);
      print_verdict();
   end
endmodule
